//--- hdl/cwsm_pkg.sv
// constants shared by the communication watchdog blocks
package cwsm_pkg;
  // apb register byte offsets
  localparam logic [7:0] CWSM_CTRL_OFS = 8'h00;
  localparam logic [7:0] CWSM_TMO_OFS = 8'h04;
  localparam logic [7:0] CWSM_STAT_OFS = 8'h08;
  localparam logic [7:0] CWSM_ELAPSED_OFS = 8'h0C;
  localparam logic [7:0] CWSM_RELEASE_OFS = 8'h10;
  localparam logic [7:0] CWSM_SAFEVAL_OFS = 8'h14;
  localparam logic [7:0] CWSM_OUTCMD_OFS = 8'h18;
  localparam logic [7:0] CWSM_INPUT_OFS = 8'h1C;
  localparam logic [7:0] CWSM_IRQSTAT_OFS = 8'h20;
  localparam logic [7:0] CWSM_IRQMASK_OFS = 8'h24;
  // field positions
  localparam int CWSM_CTRL_AUTO_BIT = 0;
  localparam int CWSM_CTRL_SVC_LSB = 1;
  localparam int CWSM_STAT_SAFE_BIT = 0;
  localparam int CWSM_STAT_LINK_BIT = 1;
  localparam int CWSM_EV_ENTER_BIT = 0;
  localparam int CWSM_EV_EXIT_BIT = 1;
  localparam int CWSM_EV_RECON_BIT = 2;
  localparam int CWSM_EV_W = 3;
  // monitored service encoding
  localparam logic [1:0] CWSM_SVC_MODBUS_TCP = 2'h0;
  // values after reset, plus the timeout-off value, seconds counter limit and release code
  localparam logic CWSM_AUTO_RST = 1'b0;
  localparam logic [1:0] CWSM_SVC_RST = 2'h0;
  localparam logic [15:0] CWSM_TMO_RST = 16'h0000;
  localparam logic [15:0] CWSM_TMO_OFF = 16'h0000;
  localparam logic [15:0] CWSM_SEC_MAX = 16'hFFFF;
  localparam logic [31:0] CWSM_RELEASE_CODE = 32'h0000_0000;
  // timing
  localparam int unsigned CWSM_CLK_PERIOD_NS = 10;
  localparam int unsigned CWSM_SECOND_NS = 1000000000;
  localparam int unsigned CWSM_BLINK_HALF_MS = 100;
  localparam int unsigned CWSM_SEC_CYCLES = CWSM_SECOND_NS / CWSM_CLK_PERIOD_NS;
  localparam int unsigned CWSM_BLINK_CYCLES = CWSM_BLINK_HALF_MS * 1000000 / CWSM_CLK_PERIOD_NS;
endpackage

//--- hdl/cwsm_tick.sv
// periodic one-cycle pulse generator with restart
`timescale 1ns/100ps
module cwsm_tick #(
  parameter int unsigned PERIOD = 16
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic clr, // hold count at zero
  output logic tick // one-cycle pulse each period
);
  localparam int CW = (PERIOD > 2) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  initial begin
    if (PERIOD < 2) $error("cwsm_tick: PERIOD must be at least 2");
  end

  logic [CW-1:0] cnt_q;

  // count cycles, registered pulse in the cycle after the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (clr) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      tick <= (cnt_q == LAST);
    end
  end
endmodule

//--- hdl/cwsm_top.sv
// communication watchdog with safe mode, apb register slave
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
module cwsm_top
  import cwsm_pkg::*;
#(
  parameter int N_OUT = 8,
  parameter int N_IN = 8,
  parameter int N_MOD = 4,
  parameter logic [N_MOD-1:0] MOD_HAS_OUT = '1,
  parameter int unsigned SEC_CYCLES = CWSM_SEC_CYCLES,
  parameter int unsigned BLINK_CYCLES = CWSM_BLINK_CYCLES
) (
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic link_up, // master connected on the service, async
  input wire logic exit_cmd, // exit safe mode command pulse
  input wire logic ext_out_wr, // output write from other access path
  input wire logic [N_OUT-1:0] ext_out_data, // data for that write
  input wire logic [N_IN-1:0] in_ch, // input channel pins, async
  output logic [N_OUT-1:0] out_ch, // output channel drive
  output logic rdy_led_red, // ready led red
  output logic rdy_led_green, // ready led green
  output logic [N_MOD-1:0] mod_led_red, // module status red
  output logic [N_MOD-1:0] mod_led_green, // module status green
  output logic irq // level interrupt
);
  initial begin
    if (N_OUT < 1 || N_OUT > 32) $error("cwsm_top: N_OUT out of 1..32");
    if (N_IN < 1 || N_IN > 32) $error("cwsm_top: N_IN out of 1..32");
    if (N_MOD < 1) $error("cwsm_top: N_MOD must be positive");
  end

  logic link_m_q, link_s_q;
  logic [N_IN-1:0] in_m_q, in_s_q;
  logic auto_q;
  logic [1:0] svc_q;
  logic [15:0] tmo_q;
  logic [15:0] disc_sec_q;
  logic safe_q;
  logic [N_OUT-1:0] safe_val_q, out_cmd_q;
  logic [CWSM_EV_W-1:0] ev_stat_q, ev_mask_q;
  logic link_prev_q;
  logic blink_q;
  logic sec_tick, blink_tick;

  // bus phase decode
  logic setup, wr_acc, rd_acc;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= CWSM_IRQMASK_OFS);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // two-flop synchronisers for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // link taken as present at reset, so no false reconnect event follows reset
      link_m_q <= 1'b1;
      link_s_q <= 1'b1;
      in_m_q <= '0;
      in_s_q <= '0;
    end else begin
      link_m_q <= link_up;
      link_s_q <= link_m_q;
      in_m_q <= in_ch;
      in_s_q <= in_m_q;
    end
  end

  // monitored connection only for the modbus tcp service
  logic svc_ok, connected, reconnect;
  assign svc_ok = (svc_q == CWSM_SVC_MODBUS_TCP);
  assign connected = link_s_q || !svc_ok;
  assign reconnect = connected && !link_prev_q;

  // manual release paths
  logic release_req;
  assign release_req = exit_cmd
    || (wr_acc && hit(paddr, CWSM_RELEASE_OFS) && pwdata == CWSM_RELEASE_CODE);

  // second tick restarts while connected so timing starts at disconnect
  cwsm_tick #(.PERIOD(SEC_CYCLES)) u_sec (
    .pclk(pclk),
    .presetn(presetn),
    .clr(connected),
    .tick(sec_tick)
  );

  cwsm_tick #(.PERIOD(BLINK_CYCLES)) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!safe_q),
    .tick(blink_tick)
  );

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= CWSM_AUTO_RST;
      svc_q <= CWSM_SVC_RST;
      tmo_q <= CWSM_TMO_RST;
      safe_val_q <= '0;
      ev_mask_q <= '0;
    end else if (wr_acc) begin
      if (hit(paddr, CWSM_CTRL_OFS)) begin
        auto_q <= pwdata[CWSM_CTRL_AUTO_BIT];
        svc_q <= pwdata[CWSM_CTRL_SVC_LSB +: 2];
      end
      if (hit(paddr, CWSM_TMO_OFS)) tmo_q <= pwdata[15:0];
      if (hit(paddr, CWSM_SAFEVAL_OFS)) safe_val_q <= pwdata[N_OUT-1:0];
      if (hit(paddr, CWSM_IRQMASK_OFS)) ev_mask_q <= pwdata[CWSM_EV_W-1:0];
    end
  end

  // normal output command, locked while in safe mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cmd_q <= '0;
    end else if (!safe_q) begin
      if (wr_acc && hit(paddr, CWSM_OUTCMD_OFS)) out_cmd_q <= pwdata[N_OUT-1:0];
      else if (ext_out_wr) out_cmd_q <= ext_out_data;
    end
  end

  // disconnected seconds counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_sec_q <= '0;
    end else if (connected || release_req) begin
      disc_sec_q <= '0;
    end else if (sec_tick && disc_sec_q != CWSM_SEC_MAX) begin
      disc_sec_q <= disc_sec_q + 16'h0001;
    end
  end

  // safe mode flag; entry wins over a clear in the same cycle
  logic enter, leave;
  assign enter = !safe_q && !connected && tmo_q != CWSM_TMO_OFF
    && disc_sec_q >= tmo_q;
  assign leave = safe_q && (release_req || (auto_q && connected));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_q <= 1'b0;
      link_prev_q <= 1'b1;
    end else begin
      link_prev_q <= connected;
      if (enter) safe_q <= 1'b1;
      else if (leave) safe_q <= 1'b0;
    end
  end

  // output drive follows safe values in safe mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) out_ch <= '0;
    else out_ch <= safe_q ? safe_val_q : out_cmd_q;
  end

  // fast blink phase and indicators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_q <= 1'b0;
      rdy_led_red <= 1'b0;
      rdy_led_green <= 1'b1;
      mod_led_red <= '0;
      mod_led_green <= '1;
    end else begin
      blink_q <= !safe_q ? 1'b1 : (blink_tick ? !blink_q : blink_q);
      rdy_led_red <= safe_q && blink_q;
      rdy_led_green <= !safe_q;
      mod_led_red <= {N_MOD{safe_q && blink_q}} & MOD_HAS_OUT;
      mod_led_green <= ~({N_MOD{safe_q}} & MOD_HAS_OUT);
    end
  end

  // sticky events, read clears, set wins
  logic [CWSM_EV_W-1:0] ev_set, ev_clr;
  always_comb begin
    ev_set = '0;
    ev_set[CWSM_EV_ENTER_BIT] = enter;
    ev_set[CWSM_EV_EXIT_BIT] = leave;
    ev_set[CWSM_EV_RECON_BIT] = reconnect;
    // clear only what the read reported, so a later event is not lost
    ev_clr = (rd_acc && hit(paddr, CWSM_IRQSTAT_OFS)) ? prdata[CWSM_EV_W-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
      irq <= |(((ev_stat_q & ~ev_clr) | ev_set) & ev_mask_q);
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      CWSM_CTRL_OFS: begin
        rd_mux[CWSM_CTRL_AUTO_BIT] = auto_q;
        rd_mux[CWSM_CTRL_SVC_LSB +: 2] = svc_q;
      end
      CWSM_TMO_OFS: rd_mux[15:0] = tmo_q;
      CWSM_STAT_OFS: begin
        rd_mux[CWSM_STAT_SAFE_BIT] = safe_q;
        rd_mux[CWSM_STAT_LINK_BIT] = link_s_q;
      end
      CWSM_ELAPSED_OFS: rd_mux[15:0] = disc_sec_q;
      CWSM_RELEASE_OFS: rd_mux[CWSM_STAT_SAFE_BIT] = safe_q;
      CWSM_SAFEVAL_OFS: rd_mux[N_OUT-1:0] = safe_val_q;
      CWSM_OUTCMD_OFS: rd_mux[N_OUT-1:0] = out_cmd_q;
      CWSM_INPUT_OFS: rd_mux[N_IN-1:0] = in_s_q;
      CWSM_IRQSTAT_OFS: rd_mux[CWSM_EV_W-1:0] = ev_stat_q;
      CWSM_IRQMASK_OFS: rd_mux[CWSM_EV_W-1:0] = ev_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: no wait state, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !mapped(paddr);
      end else if (pready) begin
        pslverr <= 1'b0;
      end
    end
  end

  // checks
  property p_no_timeout_entry;
    @(posedge pclk) disable iff (!presetn)
      (tmo_q == CWSM_TMO_OFF && !safe_q) |=> !safe_q;
  endproperty
  a_no_timeout_entry: assert property (p_no_timeout_entry) else $error("entry with timeout off");

  property p_entry_at_count;
    @(posedge pclk) disable iff (!presetn)
      $rose(safe_q) |-> $past(disc_sec_q) >= $past(tmo_q) && $past(tmo_q) != 16'h0000;
  endproperty
  a_entry_at_count: assert property (p_entry_at_count) else $error("early safe entry");

  property p_count_only_disc;
    @(posedge pclk) disable iff (!presetn)
      connected |=> disc_sec_q == 16'h0000;
  endproperty
  a_count_only_disc: assert property (p_count_only_disc) else $error("counter not reset");

  property p_safe_outputs;
    @(posedge pclk) disable iff (!presetn)
      safe_q ##1 safe_q |-> out_ch == $past(safe_val_q);
  endproperty
  a_safe_outputs: assert property (p_safe_outputs) else $error("outputs not safe");

  property p_write_locked;
    @(posedge pclk) disable iff (!presetn)
      safe_q |=> out_cmd_q == $past(out_cmd_q);
  endproperty
  a_write_locked: assert property (p_write_locked) else $error("output written in safe mode");

  property p_auto_exit;
    @(posedge pclk) disable iff (!presetn)
      (safe_q && auto_q && connected) |=> !safe_q ##1 rdy_led_green;
  endproperty
  a_auto_exit: assert property (p_auto_exit) else $error("no auto clear");

  property p_hold_no_auto;
    @(posedge pclk) disable iff (!presetn)
      (safe_q && !auto_q && !release_req) |=> safe_q;
  endproperty
  a_hold_no_auto: assert property (p_hold_no_auto) else $error("left safe mode unasked");

  property p_release_exit;
    @(posedge pclk) disable iff (!presetn)
      (safe_q && release_req) |=> !safe_q;
  endproperty
  a_release_exit: assert property (p_release_exit) else $error("release ignored");

  property p_led_in_safe;
    @(posedge pclk) disable iff (!presetn)
      safe_q ##1 safe_q |-> !rdy_led_green && rdy_led_red == $past(blink_q);
  endproperty
  a_led_in_safe: assert property (p_led_in_safe) else $error("led not blinking red");

  c_enter: cover property (@(posedge pclk) disable iff (!presetn) $rose(safe_q));
  c_auto: cover property (@(posedge pclk) disable iff (!presetn) leave && auto_q && connected);
  c_manual: cover property (@(posedge pclk) disable iff (!presetn) leave && release_req);
endmodule

//--- testbench/cwsm_master_model.sv
// remote network master model: opens and drops its session on request
`timescale 1ns/100ps
module cwsm_master_model #(
  parameter int DELAY = 2
) (
  input wire logic pclk, // system clock
  input wire logic want_conn, // bench asks for a session
  output logic link_up // session present on the monitored service
);
  // session starts open; changes reach the wire after a short stack delay
  logic [DELAY-1:0] pipe_q = '1;
  always @(posedge pclk) begin
    pipe_q <= {pipe_q[DELAY-2:0], want_conn};
  end
  assign link_up = pipe_q[DELAY-1];
endmodule

//--- testbench/cwsm_top_tb.sv
// self-checking bench for the communication watchdog over apb
`timescale 1ns/100ps
module cwsm_top_tb;
  import cwsm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, link_up, irq, rdy_led_red, rdy_led_green;
  logic exit_cmd = 1'b0;
  logic ext_out_wr = 1'b0;
  logic [7:0] ext_out_data = 8'h00;
  logic [7:0] in_ch = 8'h5A;
  logic [7:0] out_ch;
  logic [3:0] mod_led_red, mod_led_green;
  logic want_conn = 1'b1;
  int mismatches = 0;
  int check_count = 0;
  int n;
  // clock, 10 ns period
  initial begin
    forever #5 pclk = ~pclk;
  end
  cwsm_top #(.MOD_HAS_OUT(4'h5), .SEC_CYCLES(20),
    .BLINK_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_up(link_up), .exit_cmd(exit_cmd),
    .ext_out_wr(ext_out_wr), .ext_out_data(ext_out_data), .in_ch(in_ch), .out_ch(out_ch),
    .rdy_led_red(rdy_led_red), .rdy_led_green(rdy_led_green), .mod_led_red(mod_led_red),
    .mod_led_green(mod_led_green), .irq(irq));
  cwsm_master_model i_master (.pclk(pclk), .want_conn(want_conn),
    .link_up(link_up));
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] got;
    logic err;
    apb(1'b0, a, 32'h0, got, err);
    chk(got, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask
  // cycles until the ready led green reaches a level, bounded
  task automatic wait_green(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (rdy_led_green !== lvl && cnt < lim) begin
      @(posedge pclk);
      cnt++;
    end
  endtask
  // red must toggle, not sit at one level
  task automatic blink();
    int ones;
    int mods;
    ones = 0;
    mods = 0;
    repeat (12) begin
      @(posedge pclk);
      ones += int'(rdy_led_red === 1'b1);
      mods += int'(mod_led_red === (rdy_led_red ? 4'h5 : 4'h0));
    end
    chk(32'(ones > 2 && ones < 10), 32'h1);
    chk(32'(mods), 32'd12);
  endtask
  task automatic pulse_ext(input logic [7:0] d);
    @(posedge pclk);
    ext_out_wr <= 1'b1;
    ext_out_data <= d;
    @(posedge pclk);
    ext_out_wr <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    $display("timeout reached");
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(CWSM_CTRL_OFS, 32'h0, 1'b0);
    rd(CWSM_STAT_OFS, 32'h2, 1'b0);
    rd(CWSM_ELAPSED_OFS, 32'h0, 1'b0);
    rd(CWSM_TMO_OFS, 32'h0, 1'b0);
    rd(8'h30, 32'h0, 1'b1);
    chk(32'(rdy_led_green), 32'h1);
    $display("test reset done");
    // zero timeout never trips
    want_conn <= 1'b0;
    repeat (100) @(posedge pclk);
    chk(32'(rdy_led_green), 32'h1);
    rd(CWSM_STAT_OFS, 32'h0, 1'b0);
    want_conn <= 1'b1;
    $display("test disabled done");
    // timeout entry after three seconds
    wr(CWSM_SAFEVAL_OFS, 32'hA5);
    wr(CWSM_IRQMASK_OFS, 32'h7);
    wr(CWSM_TMO_OFS, 32'h3);
    rd(CWSM_IRQSTAT_OFS, 32'h4, 1'b0);
    pulse_ext(8'h66);
    repeat (3) @(posedge pclk);
    chk(32'(out_ch), 32'h66);
    chk(32'(irq), 32'h0);
    want_conn <= 1'b0;
    wait_green(1'b0, 200, n);
    chk(32'(n >= 60 && n <= 75), 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(out_ch), 32'hA5);
    chk(32'(mod_led_green), 32'hA);
    chk(32'(irq), 32'h1);
    blink();
    rd(CWSM_STAT_OFS, 32'h1, 1'b0);
    wr(CWSM_OUTCMD_OFS, 32'h11);
    pulse_ext(8'h22);
    in_ch <= 8'hC3;
    repeat (3) @(posedge pclk);
    chk(32'(out_ch), 32'hA5);
    rd(CWSM_INPUT_OFS, 32'hC3, 1'b0);
    $display("test entry done");
    // reconnect without auto-clear, then manual release
    want_conn <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(rdy_led_green), 32'h0);
    blink();
    rd(CWSM_STAT_OFS, 32'h3, 1'b0);
    rd(CWSM_ELAPSED_OFS, 32'h0, 1'b0);
    wr(CWSM_RELEASE_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(rdy_led_green), 32'h0);
    wr(CWSM_RELEASE_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(rdy_led_green), 32'h1);
    chk(32'(rdy_led_red), 32'h0);
    chk(32'(mod_led_red), 32'h0);
    chk(32'(out_ch), 32'h66);
    rd(CWSM_IRQSTAT_OFS, 32'h7, 1'b0);
    rd(CWSM_IRQSTAT_OFS, 32'h0, 1'b0);
    chk(32'(irq), 32'h0);
    $display("test manual release done");
    // exit command, re-entry, then auto-clear on reconnection
    want_conn <= 1'b0;
    wait_green(1'b0, 200, n);
    @(posedge pclk);
    exit_cmd <= 1'b1;
    @(posedge pclk);
    exit_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(rdy_led_green), 32'h1);
    wait_green(1'b0, 200, n);
    chk(32'(n >= 40 && n <= 70), 32'h1);
    wr(CWSM_CTRL_OFS, 32'h1);
    want_conn <= 1'b1;
    wait_green(1'b1, 20, n);
    chk(32'(n <= 10), 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(out_ch), 32'h66);
    chk(32'(rdy_led_red), 32'h0);
    $display("test auto clear done");
    // only the modbus tcp service is monitored
    wr(CWSM_CTRL_OFS, 32'h2);
    want_conn <= 1'b0;
    repeat (100) @(posedge pclk);
    chk(32'(rdy_led_green), 32'h1);
    want_conn <= 1'b1;
    $display("test service done");
    give_verdict();
  end
endmodule
